// [design/bit_window_shift.sv]
// Purpose: Selects the output bit window of a 12-bit sample and saturates.
// Assumes: Shift is 0 to 4; larger codes are kept out by the register file.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module bit_window_shift (
  input wire logic [pixel_gain_pkg::ADC_W-1:0] sample,
  input wire logic [pixel_gain_pkg::SHIFT_W-1:0] shift,
  input wire logic fmt8,
  output logic [pixel_gain_pkg::ADC_W-1:0] pixel,
  output logic sat
);

  logic [15:0] widened;
  logic [pixel_gain_pkg::ADC_W-1:0] over_mask;

  always_comb
  begin
    widened = {4'h0, sample} << shift;
    // Bits above the chosen window; any one set forces full scale.
    over_mask = ~(pixel_gain_pkg::PIX_FULL12 >> shift);
    sat = |(sample & over_mask);
    if (fmt8)
    begin
      // Eight bits taken from eleven-minus-shift downward.
      pixel = sat ? pixel_gain_pkg::PIX_FULL8 : {4'h0, widened[11:4]};
    end
    else
    begin
      // Low bits fill with zeros as the window moves down.
      pixel = sat ? pixel_gain_pkg::PIX_FULL12 : widened[11:0];
    end
  end

endmodule : bit_window_shift
`default_nettype wire

// [design/pixel_color_gain_bit_shift.sv]
// Purpose: Per-color balance gain followed by a selectable bit-window shift.
// Assumes: Pixels arrive one per valid cycle with their color filter position.
// Notes: Two cycles from pixel in to pixel out; 8-bit results sit in bits 7:0.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pixel_color_gain_bit_shift (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [pixel_gain_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pixel_gain_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pixel_gain_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pix_valid,
  input wire logic [pixel_gain_pkg::ADC_W-1:0] pix_data,
  input wire logic [1:0] pix_color,
  output logic out_valid,
  output logic [pixel_gain_pkg::ADC_W-1:0] out_data,
  output logic [1:0] out_color
);

  // Ratio storage, indexed by color code.
  logic [pixel_gain_pkg::RATIO_W-1:0] ratio_reg [0:2];
  logic [pixel_gain_pkg::RATIO_W-1:0] ratio_next [0:2];
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic [pixel_gain_pkg::SHIFT_W-1:0] shift_reg;
  logic [pixel_gain_pkg::SHIFT_W-1:0] shift_next;
  logic fmt8_reg;
  logic fmt8_next;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [pixel_gain_pkg::DATA_W-1:0] rdata_reg;
  logic [pixel_gain_pkg::DATA_W-1:0] rdata_next;

  // Gain stage.
  logic gain_valid_reg;
  logic gain_valid_next;
  logic [pixel_gain_pkg::ADC_W-1:0] gain_pix_reg;
  logic [pixel_gain_pkg::ADC_W-1:0] gain_pix_next;
  logic [1:0] gain_color_reg;
  logic [1:0] gain_color_next;
  logic gain_clip;

  // Output stage.
  logic out_valid_reg;
  logic out_valid_next;
  logic [pixel_gain_pkg::ADC_W-1:0] out_data_reg;
  logic [pixel_gain_pkg::ADC_W-1:0] out_data_next;
  logic [1:0] out_color_reg;
  logic [1:0] out_color_next;
  logic [pixel_gain_pkg::ADC_W-1:0] window_pix;
  logic window_sat;

  // Ratio that applies to a color code; unknown positions pass at unity.
  function automatic logic [pixel_gain_pkg::RATIO_W-1:0] ratio_of(
    input logic [1:0] color,
    input logic [pixel_gain_pkg::RATIO_W-1:0] r0,
    input logic [pixel_gain_pkg::RATIO_W-1:0] r1,
    input logic [pixel_gain_pkg::RATIO_W-1:0] r2
  );
    logic [pixel_gain_pkg::RATIO_W-1:0] r;
    unique case (color)
      pixel_gain_pkg::COLOR_RED: r = r0;
      pixel_gain_pkg::COLOR_GREEN: r = r1;
      pixel_gain_pkg::COLOR_BLUE: r = r2;
      default: r = pixel_gain_pkg::RATIO_UNITY;
    endcase
    return r;
  endfunction : ratio_of

  // Scaled value with a clip flag on top: {clip, value}.
  function automatic logic [pixel_gain_pkg::ADC_W:0] apply_gain(
    input logic [pixel_gain_pkg::ADC_W-1:0] sample,
    input logic [pixel_gain_pkg::RATIO_W-1:0] ratio
  );
    logic [pixel_gain_pkg::PROD_W-1:0] prod;
    logic [pixel_gain_pkg::PROD_W-pixel_gain_pkg::RATIO_FRAC-1:0] scaled;
    logic [pixel_gain_pkg::ADC_W:0] res;
    prod = {{pixel_gain_pkg::RATIO_W{1'b0}}, sample}
      * {{pixel_gain_pkg::ADC_W{1'b0}}, ratio};
    scaled = prod[pixel_gain_pkg::PROD_W-1:pixel_gain_pkg::RATIO_FRAC];
    if (|scaled[pixel_gain_pkg::PROD_W-pixel_gain_pkg::RATIO_FRAC-1:pixel_gain_pkg::ADC_W])
    begin
      res = {1'b1, pixel_gain_pkg::PIX_FULL12};
    end
    else
    begin
      res = {1'b0, scaled[pixel_gain_pkg::ADC_W-1:0]};
    end
    return res;
  endfunction : apply_gain

  // Register file next state.
  always_comb
  begin
    sel_next = sel_reg;
    shift_next = shift_reg;
    fmt8_next = fmt8_reg;
    status_next = status_reg;
    for (int i = 0; i < 3; i++)
    begin
      ratio_next[i] = ratio_reg[i];
    end
    rdata_next = '0;
    if (reg_wr)
    begin
      unique case (reg_addr)
        pixel_gain_pkg::ADDR_SEL:
        begin
          // The unused code is refused so the selector always names a channel.
          if (reg_wdata[1:0] != pixel_gain_pkg::COLOR_NONE)
          begin
            sel_next = reg_wdata[1:0];
          end
        end
        pixel_gain_pkg::ADDR_RATIO:
        begin
          // The full 8-bit code is legal: 0.00 to 255/64.
          ratio_next[sel_reg] = reg_wdata[pixel_gain_pkg::RATIO_W-1:0];
        end
        pixel_gain_pkg::ADDR_SHIFT:
        begin
          if (reg_wdata[pixel_gain_pkg::SHIFT_W-1:0] <= pixel_gain_pkg::SHIFT_MAX
              && reg_wdata[pixel_gain_pkg::DATA_W-1:pixel_gain_pkg::SHIFT_W] == '0)
          begin
            shift_next = reg_wdata[pixel_gain_pkg::SHIFT_W-1:0];
          end
        end
        pixel_gain_pkg::ADDR_FORMAT:
        begin
          fmt8_next = reg_wdata[pixel_gain_pkg::FMT8_BIT];
        end
        pixel_gain_pkg::ADDR_STATUS:
        begin
          status_next = status_reg & ~reg_wdata[1:0];
        end
        default:
        begin
          sel_next = sel_reg;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle.
    if (out_valid_next && window_sat)
    begin
      status_next[pixel_gain_pkg::STAT_SAT_BIT] = 1'b1;
    end
    if (gain_valid_next && gain_clip)
    begin
      status_next[pixel_gain_pkg::STAT_CLIP_BIT] = 1'b1;
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        pixel_gain_pkg::ADDR_SEL: rdata_next = {30'h0, sel_reg};
        pixel_gain_pkg::ADDR_RATIO:
          rdata_next = {24'h0, ratio_of(sel_reg, ratio_reg[0], ratio_reg[1], ratio_reg[2])};
        pixel_gain_pkg::ADDR_SHIFT: rdata_next = {29'h0, shift_reg};
        pixel_gain_pkg::ADDR_FORMAT: rdata_next = {31'h0, fmt8_reg};
        pixel_gain_pkg::ADDR_STATUS: rdata_next = {30'h0, status_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 3; i++)
      begin
        ratio_reg[i] <= pixel_gain_pkg::RATIO_UNITY;
      end
      sel_reg <= pixel_gain_pkg::COLOR_RED;
      shift_reg <= pixel_gain_pkg::SHIFT_RST;
      fmt8_reg <= pixel_gain_pkg::FMT_RST;
      status_reg <= 2'h0;
      rdata_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        ratio_reg[i] <= ratio_next[i];
      end
      sel_reg <= sel_next;
      shift_reg <= shift_next;
      fmt8_reg <= fmt8_next;
      status_reg <= status_next;
      rdata_reg <= rdata_next;
    end
  end

  // Gain stage: the ratio is picked by the pixel's filter position.
  always_comb
  begin
    gain_valid_next = pix_valid;
    gain_color_next = pix_valid ? pix_color : gain_color_reg;
    // Unity gives sample*64>>6, the sample itself; below one also lowers the ceiling.
    {gain_clip, gain_pix_next} = apply_gain(pix_data,
      ratio_of(pix_color, ratio_reg[0], ratio_reg[1], ratio_reg[2]));
    if (!pix_valid)
    begin
      gain_pix_next = gain_pix_reg;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gain_valid_reg <= 1'b0;
      gain_pix_reg <= '0;
      gain_color_reg <= 2'h0;
    end
    else
    begin
      gain_valid_reg <= gain_valid_next;
      gain_pix_reg <= gain_pix_next;
      gain_color_reg <= gain_color_next;
    end
  end

  // Shift stage: window selection and saturation.
  bit_window_shift window_u (
    .sample(gain_pix_reg),
    .shift(shift_reg),
    .fmt8(fmt8_reg),
    .pixel(window_pix),
    .sat(window_sat)
  );

  always_comb
  begin
    out_valid_next = gain_valid_reg;
    out_data_next = gain_valid_reg ? window_pix : out_data_reg;
    out_color_next = gain_valid_reg ? gain_color_reg : out_color_reg;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
      out_color_reg <= 2'h0;
    end
    else
    begin
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
      out_color_reg <= out_color_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign out_color = out_color_reg;

  // Checks.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_pix_in;
    pix_valid;
  endsequence
  sequence s_through_stages;
    ##1 gain_valid_reg ##1 out_valid;
  endsequence
  sequence s_ratio_write(logic [1:0] c);
    reg_wr && reg_addr == pixel_gain_pkg::ADDR_RATIO && sel_reg == c;
  endsequence

  AST_RATIO_RED: assert property (s_ratio_write(pixel_gain_pkg::COLOR_RED) |=>
    ratio_reg[0] == $past(reg_wdata[7:0]) && $stable(ratio_reg[1]))
    else $error("Red ratio write not stored alone.");

  AST_RATIO_FULL_RANGE: assert property (s_ratio_write(pixel_gain_pkg::COLOR_BLUE)
    && reg_wdata[7:0] == 8'hFF |=> ratio_reg[2] == 8'hFF)
    else $error("Top ratio code refused.");

  AST_UNITY_PASS: assert property (pix_valid && pix_color == pixel_gain_pkg::COLOR_GREEN
    && ratio_reg[1] == pixel_gain_pkg::RATIO_UNITY |=> gain_pix_reg == $past(pix_data))
    else $error("Unity ratio altered the pixel.");

  AST_DOUBLE_GAIN: assert property (pix_valid && pix_color == pixel_gain_pkg::COLOR_RED
    && ratio_reg[0] == 8'h80 && !pix_data[11] |=> gain_pix_reg == {$past(pix_data[10:0]), 1'b0})
    else $error("Ratio two did not double the pixel.");

  AST_CLIP_FULL: assert property (pix_valid && pix_color == pixel_gain_pkg::COLOR_BLUE
    && ratio_reg[2] == 8'h80 && pix_data[11] |=> gain_pix_reg == pixel_gain_pkg::PIX_FULL12)
    else $error("Overflowing gain did not clip.");

  AST_LATENCY: assert property (s_pix_in |-> s_through_stages)
    else $error("Pixel did not emerge two cycles later.");

  AST_NO_SHIFT12: assert property (gain_valid_reg && shift_reg == 3'h0 && !fmt8_reg
    |=> out_data == $past(gain_pix_reg))
    else $error("Unshifted 12-bit pixel changed.");

  AST_SHIFT12: assert property (gain_valid_reg && !fmt8_reg && !window_sat
    |=> out_data == 12'($past(gain_pix_reg) << $past(shift_reg)))
    else $error("12-bit window wrong.");

  AST_WINDOW8: assert property (gain_valid_reg && fmt8_reg && !window_sat
    |=> out_data == {4'h0, 8'($past(gain_pix_reg) >> (3'h4 - $past(shift_reg)))})
    else $error("8-bit window wrong.");

  AST_SATURATE: assert property (gain_valid_reg && shift_reg == 3'h2
    && |gain_pix_reg[11:10] |=> out_data == (fmt8_reg ? 12'h0FF : 12'hFFF))
    else $error("Overflow above window did not saturate.");

  AST_SHIFT_CODE: assert property (reg_wr && reg_addr == pixel_gain_pkg::ADDR_SHIFT
    && reg_wdata[2:0] > 3'h4 |=> $stable(shift_reg))
    else $error("Illegal shift code accepted.");

endmodule : pixel_color_gain_bit_shift
`default_nettype wire

// [design/pixel_gain_pkg.sv]
// Purpose: Shared constants and types for the pixel gain and bit shift stage.
// Assumes: One clock domain; registers reached over a plain strobe port.
// Notes: Ratios are unsigned fixed point with two integer and six fraction bits.
package pixel_gain_pkg;

  localparam int ADC_W = 12;
  localparam int RATIO_W = 8;
  localparam int RATIO_FRAC = 6;
  localparam int SHIFT_W = 3;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int PROD_W = ADC_W + RATIO_W;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] ADDR_SEL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RATIO = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_SHIFT = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_FORMAT = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h10;

  // Field positions.
  localparam int FMT8_BIT = 0;
  localparam int STAT_SAT_BIT = 0;
  localparam int STAT_CLIP_BIT = 1;

  // Reset values and limits.
  localparam logic [RATIO_W-1:0] RATIO_UNITY = 8'h40;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 3'h0;
  localparam logic [SHIFT_W-1:0] SHIFT_MAX = 3'h4;
  localparam logic FMT_RST = 1'b0;
  localparam logic [ADC_W-1:0] PIX_FULL12 = 12'hFFF;
  localparam logic [ADC_W-1:0] PIX_FULL8 = 12'h0FF;

  typedef enum logic [1:0]
  {
    COLOR_RED = 2'h0,
    COLOR_GREEN = 2'h1,
    COLOR_BLUE = 2'h2,
    COLOR_NONE = 2'h3
  } color_e;

endpackage : pixel_gain_pkg

// [sim/adc_sample_source.sv]
// Purpose: Stand-in for the sensor ADC that feeds the gain and shift stage.
// Assumes: One sample per request; requests change just after a rising edge.
// Notes: Between samples the data lines toggle, so a stale sample cannot pass for a new one.
`timescale 1ns/1ps
`default_nettype none
module adc_sample_source (
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [pixel_gain_pkg::ADC_W-1:0] send_data,
  input wire logic [1:0] send_color,
  output logic pix_valid,
  output logic [pixel_gain_pkg::ADC_W-1:0] pix_data,
  output logic [1:0] pix_color
);
  initial
  begin
    pix_valid = 1'b0;
    pix_data = 12'h000;
    pix_color = 2'h0;
  end

  always @(posedge clk_sys)
  begin
    pix_valid <= send;
    pix_data <= send ? send_data : ~pix_data;
    pix_color <= send ? send_color : ~pix_color;
  end
endmodule : adc_sample_source
`default_nettype wire

// [sim/pixel_color_gain_bit_shift_tb_top.sv]
// Purpose: Self-checking bench for the per-color gain and bit-window shift stage.
// Assumes: Registers are reached with one-cycle strobes; read data stand one cycle later.
// Notes: Expected pixels of the shift sweep come from a reference computation kept inside this bench.
`timescale 1ns/1ps
`default_nettype none
module pixel_color_gain_bit_shift_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [pixel_gain_pkg::ADDR_W-1:0] reg_addr = 5'h00;
  logic [pixel_gain_pkg::DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [pixel_gain_pkg::DATA_W-1:0] reg_rdata;
  logic send = 1'b0;
  logic [pixel_gain_pkg::ADC_W-1:0] send_data = 12'h000;
  logic [1:0] send_color = 2'h0;
  logic pix_valid;
  logic [pixel_gain_pkg::ADC_W-1:0] pix_data;
  logic [1:0] pix_color;
  logic out_valid;
  logic [pixel_gain_pkg::ADC_W-1:0] out_data;
  logic [1:0] out_color;
  int err_total = 0;
  int checks_done = 0;

  always #4 clk_sys = ~clk_sys;

  pixel_color_gain_bit_shift dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
    .pix_data(pix_data), .pix_color(pix_color), .out_valid(out_valid),
    .out_data(out_data), .out_color(out_color)
  );

  adc_sample_source src (
    .clk_sys(clk_sys), .send(send), .send_data(send_data), .send_color(send_color),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_color(pix_color)
  );

  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check_val("reg_rdata", exp, reg_rdata);
  endtask : rd

  // Sends one sample and waits a bounded time for its result.
  task automatic pix(input logic [11:0] d, input logic [1:0] c, input logic [11:0] exp);
    int n;
    @(posedge clk_sys);
    send <= 1'b1;
    send_data <= d;
    send_color <= c;
    @(posedge clk_sys);
    send <= 1'b0;
    n = 0;
    while (out_valid !== 1'b1 && n < 8)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 8)
    begin
      err_total++;
      results();
    end
    check_val("out_data", {20'h0, exp}, {20'h0, out_data});
    check_val("out_color", {30'h0, c}, {30'h0, out_color});
  endtask : pix

  function automatic logic [11:0] exp_pixel(input int d, input int r, input int s, input bit f8);
    int g;
    g = d * r / 64;
    if (g > 4095)
      g = 4095;
    if (s > 0 && (g >> (12 - s)) != 0)
      return f8 ? 12'h0FF : 12'hFFF;
    g = (g << s) & 4095;
    return f8 ? 12'(g >> 4) : 12'(g);
  endfunction : exp_pixel

  initial
  begin
    int c;
    int f;
    int s;
    int k;
    logic [7:0] ratios [3];
    logic [11:0] samples [3];
    ratios = '{8'h20, 8'h40, 8'h80};
    samples = '{12'h0A5, 12'h17F, 12'h800};
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(pixel_gain_pkg::ADDR_SEL, 32'h0);
    rd(pixel_gain_pkg::ADDR_RATIO, 32'h40);
    rd(pixel_gain_pkg::ADDR_SHIFT, 32'h0);
    rd(pixel_gain_pkg::ADDR_FORMAT, 32'h0);
    rd(pixel_gain_pkg::ADDR_STATUS, 32'h0);
    rd(5'h14, 32'h0);
    for (c = 0; c < 3; c++)
    begin
      wr(pixel_gain_pkg::ADDR_SEL, 32'(c));
      wr(pixel_gain_pkg::ADDR_RATIO, {24'h0, ratios[c]});
    end
    for (c = 0; c < 3; c++)
    begin
      wr(pixel_gain_pkg::ADDR_SEL, 32'(c));
      rd(pixel_gain_pkg::ADDR_RATIO, {24'h0, ratios[c]});
    end
    wr(pixel_gain_pkg::ADDR_SEL, 32'h3);
    rd(pixel_gain_pkg::ADDR_SEL, 32'h2);
    pix(12'h800, 2'h0, 12'h400);
    pix(12'hABC, 2'h1, 12'hABC);
    pix(12'h900, 2'h2, 12'hFFF);
    pix(12'h123, 2'h2, 12'h246);
    rd(pixel_gain_pkg::ADDR_STATUS, 32'h2);
    wr(pixel_gain_pkg::ADDR_STATUS, 32'h3);
    rd(pixel_gain_pkg::ADDR_STATUS, 32'h0);
    wr(pixel_gain_pkg::ADDR_SEL, 32'h0);
    wr(pixel_gain_pkg::ADDR_RATIO, 32'hFF);
    pix(12'h100, 2'h0, 12'h3FC);
    pix(12'h555, 2'h3, 12'h555);
    for (f = 0; f < 2; f++)
    begin
      wr(pixel_gain_pkg::ADDR_FORMAT, 32'(f));
      for (s = 0; s < 5; s++)
      begin
        wr(pixel_gain_pkg::ADDR_SHIFT, 32'(s));
        for (k = 0; k < 3; k++)
          pix(samples[k], 2'h1, exp_pixel(samples[k], 64, s, f[0]));
      end
    end
    rd(pixel_gain_pkg::ADDR_STATUS, 32'h1);
    wr(pixel_gain_pkg::ADDR_SHIFT, 32'h5);
    rd(pixel_gain_pkg::ADDR_SHIFT, 32'h4);
    results();
  end
endmodule : pixel_color_gain_bit_shift_tb_top
`default_nettype wire
